// [design/fio_defines.svh]
// Purpose: Constants for the fixed I/O resource port
// Assumes: One 20 MHz clock, synchronous active-high reset
// Notes: Summary of operation below
//
// Summary of operation
// RULE1: Analog input request starts one conversion, waits, returns signed 16-bit sample.
// RULE2: Analog output request passes a signed 16-bit code to the DAC.
// RULE3: Host software scales input codes to volts; fabric never does.
// RULE4: Digital terminals are reached as single lines or eight-line ports.
// RULE5: Every digital terminal supports both output drive and input sampling.
// RULE6: Digital reads return the actual synchronised pin state.
// RULE7: User logic clears output enable before expecting external input values.
// RULE8: Combined output write updates data and sets enables of addressed terminals.
// RULE9: Data-only write updates data and leaves enables unchanged.
// RULE10: Enable write controls driving per line or port, independent of data.
// RULE11: One access may address several terminals of one type at once.
// RULE12: After reset all enables are clear and output data is zero.
`ifndef FIO_DEFINES_SVH
`define FIO_DEFINES_SVH
`define FIO_SAMPLE_W 16
`define FIO_PORT_W 8
`define FIO_DATA_RST 1'b0
`define FIO_OE_RST 1'b0
`endif

// [design/fio_dio_bank.sv]
// Purpose: Per-line data and enable flops for the digital terminals
// Assumes: Write strobes and masks from the same clock domain
// Notes: One generate slice per line keeps the lines independent
`timescale 1ns/1ps
`include "fio_defines.svh"
module fio_dio_bank #(
  parameter int NLINES = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [NLINES-1:0] sel,
  input wire logic wr_data,
  input wire logic wr_en,
  input wire logic set_en,
  input wire logic [NLINES-1:0] data_in,
  input wire logic [NLINES-1:0] en_in,
  output logic [NLINES-1:0] data_r,
  output logic [NLINES-1:0] oe_r
);
  genvar i;
  generate
    for (i = 0; i < NLINES; i++) begin : g_line
      wire data_we = sel[i] & wr_data;
      wire en_we = sel[i] & (wr_en | set_en);
      wire en_nxt = set_en ? 1'b1 : en_in[i];
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          data_r[i] <= `FIO_DATA_RST; // see RULE12
          oe_r[i] <= `FIO_OE_RST; // see RULE12
        end else begin
          if (data_we) begin
            data_r[i] <= data_in[i]; // see RULE9
          end
          if (en_we) begin
            oe_r[i] <= en_nxt; // see RULE10
          end
        end
      end
    end
  endgenerate
endmodule

// [design/fio_pkg.sv]
// Purpose: Types for the fixed I/O resource port
// Assumes: Used with fio_defines.svh
// Notes: Access kinds select which digital registers a request touches
package fio_pkg;
  typedef enum logic [1:0] {
    FIO_DIG_OUT,
    FIO_DIG_DATA,
    FIO_DIG_EN,
    FIO_DIG_READ
  } fio_dig_op_t;
  typedef enum logic [1:0] {
    FIO_AI_IDLE,
    FIO_AI_START,
    FIO_AI_WAIT
  } fio_ai_state_t;
endpackage

// [design/fio_port.sv]
// Purpose: Fixed I/O resource logic: ADC start/fetch, DAC load, tri-state digital lines
// Assumes: The ADC answers with a done strobe; pins arrive asynchronously
// Notes: Digital reads lag the pin by the two synchroniser stages
`timescale 1ns/1ps
`include "fio_defines.svh"
module fio_port
  import fio_pkg::*;
#(
  parameter int NPORTS = 2,
  parameter int NAI = 2,
  parameter int NAO = 2
) (
  input wire logic ref_clk,
  input wire logic rst,
  // Analog input request side
  input wire logic ai_req,
  input wire logic [NAI-1:0] ai_sel,
  output logic ai_busy,
  output logic ai_valid,
  output logic signed [NAI*`FIO_SAMPLE_W-1:0] ai_sample,
  // ADC side
  output logic [NAI-1:0] adc_start,
  input wire logic adc_done,
  input wire logic [NAI*`FIO_SAMPLE_W-1:0] adc_data,
  // Analog output
  input wire logic ao_req,
  input wire logic [NAO-1:0] ao_sel,
  input wire logic [NAO*`FIO_SAMPLE_W-1:0] ao_code,
  output logic [NAO-1:0] dac_load,
  output logic [NAO*`FIO_SAMPLE_W-1:0] dac_code,
  // Digital request side
  input wire logic dig_req,
  input wire fio_dig_op_t dig_op,
  input wire logic dig_port_mode,
  input wire logic [NPORTS*`FIO_PORT_W-1:0] dig_sel,
  input wire logic [NPORTS*`FIO_PORT_W-1:0] dig_wdata,
  input wire logic [NPORTS*`FIO_PORT_W-1:0] dig_wen,
  output logic dig_rvalid,
  output logic [NPORTS*`FIO_PORT_W-1:0] dig_rdata,
  // Pins
  input wire logic [NPORTS*`FIO_PORT_W-1:0] dio_i,
  output logic [NPORTS*`FIO_PORT_W-1:0] dio_o,
  output logic [NPORTS*`FIO_PORT_W-1:0] dio_oe
);
  localparam int NL = NPORTS * `FIO_PORT_W;
  localparam int SW = `FIO_SAMPLE_W;

  // Empty masks would leave a resource type with no terminal to address
  if (NPORTS < 1 || NAI < 1 || NAO < 1) begin : g_size_check
    $error("fio_port needs at least one terminal of each type");
  end

  // Port mode widens each selected port bit to its eight lines
  function automatic logic [NL-1:0] widen(input logic [NL-1:0] s);
    logic [NL-1:0] w;
    w = '0;
    for (int p = 0; p < NPORTS; p++) begin
      w[p*`FIO_PORT_W +: `FIO_PORT_W] = {`FIO_PORT_W{s[p]}};
    end
    return w;
  endfunction

  // Digital decode
  // One op per request; the op picks which per-line registers it touches
  wire [NL-1:0] line_sel = dig_port_mode ? widen(dig_sel) : dig_sel; // see RULE4, RULE11
  wire is_out = dig_req && (dig_op == FIO_DIG_OUT);
  wire is_data = dig_req && (dig_op == FIO_DIG_DATA);
  wire is_en = dig_req && (dig_op == FIO_DIG_EN);
  wire is_rd = dig_req && (dig_op == FIO_DIG_READ);
  wire wr_data = is_out | is_data; // see RULE8, RULE9
  wire wr_en = is_en; // see RULE10
  wire set_en = is_out; // see RULE8
  wire [NL-1:0] en_src = dig_port_mode ? widen(dig_wen) : dig_wen;

  logic [NL-1:0] data_q;
  logic [NL-1:0] oe_q;

  fio_dio_bank #(.NLINES(NL)) u_bank (
    .ref_clk(ref_clk),
    .rst(rst),
    .sel(line_sel),
    .wr_data(wr_data),
    .wr_en(wr_en),
    .set_en(set_en),
    .data_in(dig_wdata),
    .en_in(en_src),
    .data_r(data_q),
    .oe_r(oe_q)
  );

  // Pin synchroniser; stage one feeds only stage two
  logic [NL-1:0] pin_s1_r;
  logic [NL-1:0] pin_s2_r;
  logic [NL-1:0] dio_o_r;
  logic [NL-1:0] dio_oe_r;
  logic dig_rvalid_r;
  logic [NL-1:0] dig_rdata_r;
  // Unselected lines read zero so a port read shows only its own lines
  wire [NL-1:0] rd_nxt = pin_s2_r & line_sel;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      dio_o_r <= '0;
      dio_oe_r <= '0; // see RULE12
      dig_rvalid_r <= 1'b0;
      dig_rdata_r <= '0;
    end else begin
      pin_s1_r <= dio_i;
      pin_s2_r <= pin_s1_r;
      dio_o_r <= data_q; // see RULE5
      dio_oe_r <= oe_q; // see RULE5
      dig_rvalid_r <= is_rd;
      // Read data holds between reads; only the strobe pulses
      if (is_rd) begin
        // Pad reflects own drive while enabled; external drive needs oe cleared
        dig_rdata_r <= rd_nxt; // see RULE6, RULE7
      end
    end
  end

  assign dio_o = dio_o_r;
  assign dio_oe = dio_oe_r;
  assign dig_rvalid = dig_rvalid_r;
  assign dig_rdata = dig_rdata_r;

  // Analog input sequencer
  fio_ai_state_t ai_st_r;
  fio_ai_state_t ai_st_nxt;
  logic [NAI-1:0] ai_sel_r;
  logic [NAI-1:0] adc_start_r;
  logic ai_valid_r;
  logic ai_busy_r;
  logic [NAI*SW-1:0] ai_sample_r;

  wire ai_take = (ai_st_r == FIO_AI_IDLE) && ai_req && (ai_sel != '0);

  always_comb begin
    ai_st_nxt = ai_st_r;
    case (ai_st_r)
      FIO_AI_IDLE: begin
        if (ai_take) begin
          ai_st_nxt = FIO_AI_START;
        end
      end
      FIO_AI_START: begin
        ai_st_nxt = FIO_AI_WAIT;
      end
      FIO_AI_WAIT: begin
        if (adc_done) begin
          ai_st_nxt = FIO_AI_IDLE;
        end
      end
      default: begin
        ai_st_nxt = FIO_AI_IDLE;
      end
    endcase
  end

  genvar k;
  generate
    for (k = 0; k < NAI; k++) begin : g_ai
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          ai_sample_r[k*SW +: SW] <= '0;
        end else if (ai_st_r == FIO_AI_WAIT && adc_done && ai_sel_r[k]) begin
          ai_sample_r[k*SW +: SW] <= adc_data[k*SW +: SW]; // see RULE1
        end
      end
    end
  endgenerate

  // Registered from the next state so busy keeps the timing of the state flop
  wire ai_busy_nxt = (ai_st_nxt != FIO_AI_IDLE);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ai_st_r <= FIO_AI_IDLE;
      ai_sel_r <= '0;
      adc_start_r <= '0;
      ai_valid_r <= 1'b0;
      ai_busy_r <= 1'b0;
    end else begin
      ai_st_r <= ai_st_nxt;
      ai_busy_r <= ai_busy_nxt; // see RULE1
      if (ai_take) begin
        ai_sel_r <= ai_sel; // see RULE11
      end
      // One conversion start per request
      adc_start_r <= ai_take ? ai_sel : '0; // see RULE1
      ai_valid_r <= (ai_st_r == FIO_AI_WAIT) && adc_done; // see RULE1
    end
  end

  // Busy holds the requester from acceptance until the result lands
  assign ai_busy = ai_busy_r;
  assign adc_start = adc_start_r;
  assign ai_valid = ai_valid_r;
  assign ai_sample = ai_sample_r;

  // Analog output: code is passed unscaled; volts conversion stays on the host
  // A zero mask raises no load strobe and leaves every code as it was
  logic [NAO-1:0] dac_load_r;
  logic [NAO*SW-1:0] dac_code_r;
  generate
    for (k = 0; k < NAO; k++) begin : g_ao
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          dac_code_r[k*SW +: SW] <= '0;
          dac_load_r[k] <= 1'b0;
        end else begin
          dac_load_r[k] <= ao_req & ao_sel[k];
          if (ao_req && ao_sel[k]) begin
            dac_code_r[k*SW +: SW] <= ao_code[k*SW +: SW]; // see RULE2, RULE3
          end
        end
      end
    end
  endgenerate
  assign dac_load = dac_load_r;
  assign dac_code = dac_code_r;
endmodule

// [tb/fio_board.sv]
// Purpose: Board model: ADC and external pin drivers
// Assumes: Latency and codes set by the bench
// Notes: Undriven pins toggle so stale values never pass
`timescale 1ns/1ps
module fio_board (
  input wire logic ref_clk,
  input wire logic [1:0] adc_start,
  input wire logic [3:0] lat,
  input wire logic [31:0] code,
  output logic adc_done,
  output logic [31:0] adc_data,
  input wire logic [15:0] dio_o,
  input wire logic [15:0] dio_oe,
  input wire logic [15:0] ext_v,
  input wire logic [15:0] ext_oe,
  output logic [15:0] dio_i
);
  int cnt = 0;
  logic tog = 1'b0;
  initial adc_done = 1'b0;
  always @(posedge ref_clk) begin
    tog <= ~tog;
    adc_done <= cnt == 1;
    if (adc_start != 2'h0) cnt <= lat + 1;
    else if (cnt != 0) cnt <= cnt - 1;
  end
  // Raw codes only, volts scaling stays with host software
  assign adc_data = adc_done ? code : ~code;
  assign dio_i = dio_oe & dio_o | ~dio_oe & (ext_oe & ext_v | ~ext_oe & {16{tog}});
endmodule

// [tb/fio_port_properties.sv]
// Purpose: Timing checks on fio_port
// Assumes: Bound to every fio_port
// Notes: Read data is left to the bench
`timescale 1ns/1ps
module fio_port_properties
  import fio_pkg::*;
#(
  parameter int NPORTS = 2,
  parameter int NAI = 2,
  parameter int NAO = 2
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ai_req,
  input wire logic [NAI-1:0] ai_sel,
  input wire logic ai_busy,
  input wire logic ai_valid,
  input wire logic [NAI-1:0] adc_start,
  input wire logic adc_done,
  input wire logic ao_req,
  input wire logic [NAO-1:0] ao_sel,
  input wire logic [NAO-1:0] dac_load,
  input wire logic dig_req,
  input wire fio_dig_op_t dig_op,
  input wire logic dig_port_mode,
  input wire logic [NPORTS*8-1:0] dig_sel,
  input wire logic dig_rvalid,
  input wire logic [NPORTS*8-1:0] dio_oe
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  wire go = ai_req && !ai_busy && ai_sel != '0;
  wire wr = dig_req && !dig_port_mode;
  a_ai_start: assert property (go |=> adc_start == $past(ai_sel) && ai_busy)
    else $error("no start");
  a_ai_result: assert property (adc_done && ai_busy |=> ai_valid && !ai_busy)
    else $error("no result");
  a_start_pulse: assert property (adc_start != '0 |=> adc_start == '0 && ai_busy)
    else $error("start held");
  a_ao_load: assert property (ao_req |=> dac_load == $past(ao_sel))
    else $error("bad load");
  a_read_valid: assert property (dig_req && dig_op == FIO_DIG_READ |=> dig_rvalid)
    else $error("no rvalid");
  a_out_enable: assert property (wr && dig_op == FIO_DIG_OUT |=> ##1
    (dio_oe & $past(dig_sel, 2)) == $past(dig_sel, 2))
    else $error("oe not set");
  a_data_keeps: assert property (dig_req && dig_op == FIO_DIG_DATA |=> ##1 $stable(dio_oe))
    else $error("oe moved");
  a_reset_idle: assert property ($fell(rst) |-> dio_oe == '0 && !ai_busy)
    else $error("not idle");
  c_ai: cover property (ai_valid);
  c_port: cover property (dig_req && dig_port_mode && dig_op == FIO_DIG_OUT);
  c_ao: cover property (dac_load != '0);
endmodule
bind fio_port fio_port_properties #(.NPORTS(NPORTS), .NAI(NAI), .NAO(NAO)) i_props (
  .ref_clk(ref_clk), .rst(rst), .ai_req(ai_req), .ai_sel(ai_sel), .ai_busy(ai_busy),
  .ai_valid(ai_valid), .adc_start(adc_start), .adc_done(adc_done), .ao_req(ao_req),
  .ao_sel(ao_sel), .dac_load(dac_load), .dig_req(dig_req), .dig_op(dig_op),
  .dig_port_mode(dig_port_mode), .dig_sel(dig_sel), .dig_rvalid(dig_rvalid), .dio_oe(dio_oe));

// [tb/fio_port_tb.sv]
// Purpose: Self-checking bench for fio_port
// Assumes: Default sizes, 20 MHz clock
// Notes: Results matched in order from a queue
`timescale 1ns/1ps
module fio_port_tb;
  import fio_pkg::*;
  logic ref_clk = 0, rst = 1, ai_req = 0, ao_req = 0, dig_req = 0, dig_port_mode = 0;
  logic ai_busy, ai_valid, adc_done, dig_rvalid;
  logic [1:0] ai_sel = 0, ao_sel = 0, adc_start, dac_load;
  logic [31:0] ai_sample, adc_data, dac_code, ao_code = 0, code = 0, m;
  logic [15:0] dig_sel = 0, dig_wdata = 0, dig_wen = 0, dig_rdata, dio_i, dio_o, dio_oe;
  logic [15:0] ext_v = 0, ext_oe = 0, m_d = 0, m_oe = 0, ln;
  logic [3:0] lat = 0;
  fio_dig_op_t dig_op = FIO_DIG_READ;
  logic [63:0] q[$];
  int fails = 0, n_compared = 0;
  fio_port i_fio_port (.ref_clk(ref_clk), .rst(rst), .ai_req(ai_req), .ai_sel(ai_sel),
    .ai_busy(ai_busy), .ai_valid(ai_valid), .ai_sample(ai_sample), .adc_start(adc_start),
    .adc_done(adc_done), .adc_data(adc_data), .ao_req(ao_req), .ao_sel(ao_sel),
    .ao_code(ao_code), .dac_load(dac_load), .dac_code(dac_code), .dig_req(dig_req),
    .dig_op(dig_op), .dig_port_mode(dig_port_mode), .dig_sel(dig_sel), .dig_wdata(dig_wdata),
    .dig_wen(dig_wen), .dig_rvalid(dig_rvalid), .dig_rdata(dig_rdata), .dio_i(dio_i),
    .dio_o(dio_o), .dio_oe(dio_oe));
  fio_board i_fio_board (.ref_clk(ref_clk), .adc_start(adc_start), .lat(lat), .code(code),
    .adc_done(adc_done), .adc_data(adc_data), .dio_o(dio_o), .dio_oe(dio_oe), .ext_v(ext_v),
    .ext_oe(ext_oe), .dio_i(dio_i));
  always #25 ref_clk = ~ref_clk;
  task automatic tick;
    @(posedge ref_clk);
    #2;
  endtask
  task automatic chk(input logic [63:0] e, input logic [31:0] g);
    n_compared++;
    if ((g & e[63:32]) !== e[31:0]) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e[31:0]);
    end
  endtask
  task automatic dig(input fio_dig_op_t op, input logic [15:0] s, w, e, input logic p);
    logic [15:0] el;
    dig_req = 1;
    dig_op = op;
    dig_sel = s;
    dig_wdata = w;
    dig_wen = e;
    dig_port_mode = p;
    ln = p ? {{8{s[1]}}, {8{s[0]}}} : s;
    // Port mode takes one enable bit per port, like the select mask
    el = p ? {{8{e[1]}}, {8{e[0]}}} : e;
    if (op == FIO_DIG_READ) begin
      q.push_back({32'h0000ffff, 16'h0, (m_oe & m_d | ~m_oe & ext_v) & ln});
    end
    if (op == FIO_DIG_OUT || op == FIO_DIG_DATA) m_d = m_d & ~ln | w & ln;
    if (op == FIO_DIG_OUT) m_oe = m_oe | ln;
    if (op == FIO_DIG_EN) m_oe = m_oe & ~ln | el & ln;
    tick;
  endtask
  task automatic results;
    if (q.size() != 0) begin
      fails++;
      $display("[FAIL] %0t %0d expected results never came", $time, q.size());
    end
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Results never overlap in time, so one queue serves all three kinds
  always @(posedge ref_clk) begin
    #1;
    if (ai_valid === 1'b1 || dig_rvalid === 1'b1 || dac_load !== 2'h0) begin
      if (q.size() == 0) begin
        fails++;
        $display("[FAIL] %0t unexpected result", $time);
      end else chk(q.pop_front(), ai_valid ? ai_sample : dig_rvalid ? dig_rdata : dac_code);
    end
  end
  initial begin
    #(4000 * 50);
    fails++;
    $display("[FAIL] %0t watchdog expired", $time);
    results;
  end
  initial begin
    logic p;
    void'($urandom(49));
    repeat (5) tick;
    rst = 0;
    chk(64'hffffffff_00000000, {dio_o, dio_oe});
    for (int i = 0; i < 40; i++) begin
      p = $urandom % 2;
      dig(fio_dig_op_t'($urandom % 3), p ? $urandom % 4 : $urandom, $urandom, $urandom, p);
      dig(fio_dig_op_t'($urandom % 3), $urandom, $urandom, $urandom, 0);
      dig_req = 0;
      ext_v = $urandom;
      ext_oe = ~m_oe;
      repeat (6) tick;
      chk({32'hffffffff, m_d, m_oe}, {dio_o, dio_oe});
      dig(FIO_DIG_READ, $urandom, 0, 0, p);
      dig_req = 0;
      tick;
    end
    $display("digital test done");
    rst = 1;
    repeat (2) tick;
    rst = 0;
    m_d = 0;
    m_oe = 0;
    chk(64'hffffffff_00000000, {dio_o, dio_oe});
    $display("reset test done");
    // A request with no channel selected must be ignored
    ai_req = 1;
    tick;
    ai_req = 0;
    tick;
    for (int i = 0; i < 6; i++) begin
      ai_sel = 1 + $urandom % 3;
      code = $urandom;
      lat = $urandom % 7;
      m = {{16{ai_sel[1]}}, {16{ai_sel[0]}}};
      q.push_back({m, code & m});
      ai_req = 1;
      tick;
      ai_req = 0;
      tick;
      ai_sel = 2'h3;
      ai_req = 1;
      tick;
      ai_req = 0;
      repeat (12) tick;
    end
    $display("analog input test done");
    for (int i = 0; i < 4; i++) begin
      ao_sel = $urandom % 4;
      ao_code = $urandom;
      m = {{16{ao_sel[1]}}, {16{ao_sel[0]}}};
      if (ao_sel != 0) q.push_back({m, ao_code & m});
      ao_req = 1;
      tick;
    end
    ao_req = 0;
    repeat (4) tick;
    $display("analog output test done");
    results;
  end
endmodule
